// ==== design/dmac_pkg.sv ====
// Purpose: shared constants, types and helpers of the dma channel
// Assumes: one clock, synchronous active-high reset
// Notes: width codes 0 byte, 1 halfword, 2 word; code 3 behaves as byte
package dmac_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int CTRL_W = 14;
  localparam int NUM_CHANNELS = 8;

  // control word field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_ALL_DONE_IE = 1;
  localparam int CTRL_HALF_DONE_IE = 2;
  localparam int CTRL_DIR_FROM_MEM = 3;
  localparam int CTRL_WRAPAROUND = 4;
  localparam int CTRL_PERIPH_INC = 5;
  localparam int CTRL_MEM_INC = 6;
  localparam int CTRL_PERIPH_WIDTH_LO = 7;
  localparam int CTRL_MEM_WIDTH_LO = 9;
  localparam int CTRL_PRIORITY_LO = 11;
  localparam int CTRL_MEM_COPY = 13;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h2,
    ST_RELEASE = 2'h3
  } dmac_state_t;

  // address step for one item of the given width
  function automatic logic [ADDR_W-1:0] width_bytes(input logic [1:0] w);
    unique case (w)
      WIDTH_HALF: width_bytes = 32'h0000_0002;
      WIDTH_WORD: width_bytes = 32'h0000_0004;
      default: width_bytes = 32'h0000_0001;
    endcase
  endfunction

  // keep only the least significant bytes of the given width, zero above
  function automatic logic [DATA_W-1:0] fit_width(input logic [DATA_W-1:0] d,
                                                  input logic [1:0] w);
    unique case (w)
      WIDTH_HALF: fit_width = {16'h0000, d[15:0]};
      WIDTH_WORD: fit_width = d;
      default: fit_width = {24'h00_0000, d[7:0]};
    endcase
  endfunction

endpackage

// ==== design/dmac_ptr_if.sv ====
// Purpose: carrier between the channel and one current-address stepper
// Assumes: driven in the channel clock domain
// Notes: owner supplies base and controls, stepper returns the current address
`timescale 1ns/1ns
interface dmac_ptr_if;
  logic [dmac_pkg::ADDR_W-1:0] base;
  logic [dmac_pkg::ADDR_W-1:0] cur;
  logic [1:0] width;
  logic inc_en;
  logic load;
  logic step;

  modport owner (output base, output width, output inc_en, output load, output step,
                 input cur);
  modport stepper (input base, input width, input inc_en, input load, input step,
                   output cur);
endinterface

// ==== design/dmac_addr_step.sv ====
// Purpose: hidden current-address register of one side of the channel
// Assumes: load and step are one-cycle pulses from the owner
// Notes: load wins over step, so a wraparound reload is never advanced
`timescale 1ns/1ns
module dmac_addr_step (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  dmac_ptr_if.stepper ptr // base, controls and current address
);

  logic [dmac_pkg::ADDR_W-1:0] cur_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_reg <= dmac_pkg::ADDR_RESET;
    end else if (ptr.load) begin
      cur_reg <= ptr.base;
    end else if (ptr.step && ptr.inc_en) begin
      cur_reg <= cur_reg + dmac_pkg::width_bytes(ptr.width);
    end
  end

  assign ptr.cur = cur_reg;

endmodule

// ==== design/dmac_arbiter.sv ====
// Purpose: fixed two-stage arbiter among the channels of the controller
// Assumes: level 3 is the highest software priority
// Notes: purely combinational; the winner's request drops once it starts, its sequencer then holds the transfer
`timescale 1ns/1ns
module dmac_arbiter #(
  parameter int NCH = 8 // number of channels
) (
  input wire logic [NCH-1:0] req, // pending channels
  input wire logic [2*NCH-1:0] level, // two-bit level per channel
  output logic [NCH-1:0] grant // one-hot winner
);

  always_comb begin
    logic [1:0] best;
    logic found;
    best = 2'h0;
    found = 1'b0;
    grant = '0;
    for (int i = 0; i < NCH; i++) begin
      // strictly greater keeps the lowest index among equal levels
      if (req[i] && (!found || level[2*i +: 2] > best)) begin
        best = level[2*i +: 2];
        found = 1'b1;
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

endmodule

// ==== design/dmac_channel.sv ====
// Purpose: one dma channel moving items between a peripheral and memory
// Assumes: simple system bus master port, ready pulses one cycle per beat
// Notes: peers of the controller are seen only through their requests/levels
// Behaviour
// - peripheral and memory item widths are chosen independently in control
// - an enabled increment advances that side by 1, 2 or 4 bytes
// - first transfer uses the bases; bases stay, hidden pointers advance
// - current address registers are invisible to software
// - without wraparound, requests are ignored once the count is zero
// - disabling keeps control and base address registers intact
// - wraparound reloads count and pointers after the last item, keeps serving
// - each completed transaction lowers the remaining count by one, unless it is the last item with wraparound set
// - control holds a two-bit priority level for arbitration
// - control holds direction, wraparound, increments, widths, flag enables
// - once enabled the channel serves its peripheral's requests
// - half-way point sets the half flag, with interrupt if enabled
// - final item sets the all-done flag, with interrupt if enabled
// - memory-copy mode starts on enable without a peripheral request
// - memory-copy mode stops when the count reaches zero
// - byte to byte copies one byte, both sides step by one
// - byte to halfword zero-extends, source steps one, destination two
// - request held until acknowledged; acknowledge drops after request drops
// - equal levels resolve to the lowest channel number
`timescale 1ns/1ns
module dmac_channel #(
  parameter int NCH = dmac_pkg::NUM_CHANNELS, // channels in the controller
  parameter int CH_INDEX = 0 // this channel's hardware number
) (
  input wire logic clock, // 100 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic control_we, // write strobe for the control word
  input wire logic [dmac_pkg::CTRL_W-1:0] control_wdata, // new control word
  input wire logic periph_base_we, // write strobe for peripheral base
  input wire logic [dmac_pkg::ADDR_W-1:0] periph_base_wdata, // new peripheral base
  input wire logic mem_base_we, // write strobe for memory base
  input wire logic [dmac_pkg::ADDR_W-1:0] mem_base_wdata, // new memory base
  input wire logic count_we, // write strobe for item count
  input wire logic [dmac_pkg::COUNT_W-1:0] count_wdata, // new item count
  input wire logic half_done_clear, // clears half flag
  input wire logic all_done_clear, // clears all-done flag
  input wire logic periph_req, // request from the attached peripheral
  input wire logic [NCH-1:0] peer_pending, // pending lines of all channels
  input wire logic [2*NCH-1:0] peer_levels, // priority levels of all channels
  input wire logic bus_ready, // system bus completes the current beat
  input wire logic [dmac_pkg::DATA_W-1:0] bus_rdata, // read data from system bus
  output logic [dmac_pkg::CTRL_W-1:0] channel_control_reg, // control readback
  output logic [dmac_pkg::ADDR_W-1:0] peripheral_base_addr_reg, // base readback
  output logic [dmac_pkg::ADDR_W-1:0] memory_base_addr_reg, // base readback
  output logic [dmac_pkg::COUNT_W-1:0] remaining_items_reg, // items still to move
  output logic half_done_flag, // half-way event, sticky
  output logic all_done_flag, // completion event, sticky
  output logic irq, // channel interrupt request
  output logic pending, // this channel wants the bus
  output logic periph_ack, // acknowledge to the peripheral
  output logic bus_req, // system bus access in progress
  output logic bus_write, // access is a write
  output logic [dmac_pkg::ADDR_W-1:0] bus_addr, // access address
  output logic [1:0] bus_size, // access width code
  output logic [dmac_pkg::DATA_W-1:0] bus_wdata // write data
);

  dmac_pkg::dmac_state_t state_reg;
  logic [dmac_pkg::COUNT_W-1:0] programmed_reg;
  logic enable_prev_reg;
  logic done_half_reg;
  logic irq_reg;
  logic pending_reg;
  logic ack_reg;
  logic req_reg;
  logic write_reg;
  logic [dmac_pkg::ADDR_W-1:0] addr_reg;
  logic [1:0] size_reg;
  logic [dmac_pkg::DATA_W-1:0] wdata_reg;

  logic en;
  logic from_mem;
  logic wrap;
  logic mem_copy;
  logic [1:0] periph_w;
  logic [1:0] mem_w;
  logic [1:0] src_w;
  logic [1:0] dst_w;
  logic [1:0] level;
  logic [dmac_pkg::ADDR_W-1:0] src_addr;
  logic [dmac_pkg::ADDR_W-1:0] dst_addr;
  logic [dmac_pkg::COUNT_W-1:0] count_next;
  logic [NCH-1:0] all_req;
  logic [2*NCH-1:0] all_levels;
  logic [NCH-1:0] grant;
  logic want;
  logic start;
  logic xfer_done;
  logic last_item;
  logic half_hit;
  logic enable_rise;

  dmac_ptr_if periph_ptr ();
  dmac_ptr_if mem_ptr ();

  // control field decode
  assign en = channel_control_reg[dmac_pkg::CTRL_ENABLE];
  assign from_mem = channel_control_reg[dmac_pkg::CTRL_DIR_FROM_MEM];
  assign wrap = channel_control_reg[dmac_pkg::CTRL_WRAPAROUND];
  assign mem_copy = channel_control_reg[dmac_pkg::CTRL_MEM_COPY];
  assign periph_w = channel_control_reg[dmac_pkg::CTRL_PERIPH_WIDTH_LO +: 2];
  assign mem_w = channel_control_reg[dmac_pkg::CTRL_MEM_WIDTH_LO +: 2];
  assign level = channel_control_reg[dmac_pkg::CTRL_PRIORITY_LO +: 2];

  // source is the peripheral side unless the direction reads memory
  assign src_w = from_mem ? mem_w : periph_w;
  assign dst_w = from_mem ? periph_w : mem_w;
  assign src_addr = from_mem ? mem_ptr.cur : periph_ptr.cur;
  assign dst_addr = from_mem ? periph_ptr.cur : mem_ptr.cur;

  // hidden current pointers, no software path reaches them
  assign periph_ptr.base = peripheral_base_addr_reg;
  assign periph_ptr.width = periph_w;
  assign periph_ptr.inc_en = channel_control_reg[dmac_pkg::CTRL_PERIPH_INC];
  assign mem_ptr.base = memory_base_addr_reg;
  assign mem_ptr.width = mem_w;
  assign mem_ptr.inc_en = channel_control_reg[dmac_pkg::CTRL_MEM_INC];

  assign enable_rise = en && !enable_prev_reg;
  assign xfer_done = (state_reg == dmac_pkg::ST_WRITE) && bus_ready;
  assign last_item = remaining_items_reg == dmac_pkg::COUNT_ONE;
  assign count_next = remaining_items_reg - dmac_pkg::COUNT_ONE;
  assign half_hit = xfer_done && (count_next == (programmed_reg >> 1));

  // load on enable so the first beat uses the bases; reload at wrap end
  assign periph_ptr.load = enable_rise || (xfer_done && last_item && wrap);
  assign mem_ptr.load = enable_rise || (xfer_done && last_item && wrap);
  assign periph_ptr.step = xfer_done;
  assign mem_ptr.step = xfer_done;

  dmac_addr_step periph_step (
    .clock(clock),
    .rst(rst),
    .ptr(periph_ptr)
  );

  dmac_addr_step mem_step (
    .clock(clock),
    .rst(rst),
    .ptr(mem_ptr)
  );

  // a zero count blocks service: without wraparound it never refills
  // on its own, and memory-copy stops there as well
  assign want = en && (remaining_items_reg != dmac_pkg::COUNT_RESET)
                && (mem_copy || (periph_req && !ack_reg))
                && (state_reg == dmac_pkg::ST_IDLE)
                && !enable_rise;

  always_comb begin
    all_req = peer_pending;
    all_levels = peer_levels;
    all_req[CH_INDEX] = want;
    all_levels[2*CH_INDEX +: 2] = level;
  end

  dmac_arbiter #(
    .NCH(NCH)
  ) arbiter (
    .req(all_req),
    .level(all_levels),
    .grant(grant)
  );

  assign start = want && grant[CH_INDEX];

  // control word: writable at any time so software can disable mid-pass
  always_ff @(posedge clock) begin
    if (rst) begin
      channel_control_reg <= dmac_pkg::CTRL_RESET;
    end else if (control_we) begin
      channel_control_reg <= control_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      peripheral_base_addr_reg <= dmac_pkg::ADDR_RESET;
    end else if (periph_base_we) begin
      peripheral_base_addr_reg <= periph_base_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      memory_base_addr_reg <= dmac_pkg::ADDR_RESET;
    end else if (mem_base_we) begin
      memory_base_addr_reg <= mem_base_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      enable_prev_reg <= 1'b0;
    end else begin
      enable_prev_reg <= en;
    end
  end

  // count: new values only while disabled, so a pass never changes length
  always_ff @(posedge clock) begin
    if (rst) begin
      remaining_items_reg <= dmac_pkg::COUNT_RESET;
      programmed_reg <= dmac_pkg::COUNT_RESET;
    end else if (count_we && !en) begin
      remaining_items_reg <= count_wdata;
      programmed_reg <= count_wdata;
    end else if (xfer_done) begin
      if (last_item && wrap) begin
        remaining_items_reg <= programmed_reg;
      end else begin
        remaining_items_reg <= count_next;
      end
    end
  end

  // transaction sequencer: read beat, write beat, then release handshake unless in memory-copy mode
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= dmac_pkg::ST_IDLE;
      req_reg <= 1'b0;
      write_reg <= 1'b0;
      addr_reg <= dmac_pkg::ADDR_RESET;
      size_reg <= dmac_pkg::WIDTH_BYTE;
      wdata_reg <= '0;
    end else begin
      unique case (state_reg)
        dmac_pkg::ST_IDLE: begin
          if (start) begin
            state_reg <= dmac_pkg::ST_READ;
            req_reg <= 1'b1;
            write_reg <= 1'b0;
            addr_reg <= src_addr;
            size_reg <= src_w;
          end
        end
        dmac_pkg::ST_READ: begin
          if (bus_ready) begin
            state_reg <= dmac_pkg::ST_WRITE;
            write_reg <= 1'b1;
            addr_reg <= dst_addr;
            size_reg <= dst_w;
            // source trimmed to its width, then to the destination width
            wdata_reg <= dmac_pkg::fit_width(dmac_pkg::fit_width(bus_rdata, src_w),
                                             dst_w);
          end
        end
        dmac_pkg::ST_WRITE: begin
          if (bus_ready) begin
            req_reg <= 1'b0;
            write_reg <= 1'b0;
            state_reg <= mem_copy ? dmac_pkg::ST_IDLE : dmac_pkg::ST_RELEASE;
          end
        end
        dmac_pkg::ST_RELEASE: begin
          if (!periph_req) begin
            state_reg <= dmac_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // acknowledge rises with the first access, falls after the request drops
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else if (start && !mem_copy) begin
      ack_reg <= 1'b1;
    end else if (state_reg == dmac_pkg::ST_RELEASE && !periph_req) begin
      ack_reg <= 1'b0;
    end
  end

  // sticky flags: a new event in the clearing cycle keeps the flag set
  always_ff @(posedge clock) begin
    if (rst) begin
      done_half_reg <= 1'b0;
    end else if (half_hit) begin
      done_half_reg <= 1'b1;
    end else if (half_done_clear) begin
      done_half_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      all_done_flag <= 1'b0;
    end else if (xfer_done && last_item) begin
      all_done_flag <= 1'b1;
    end else if (all_done_clear) begin
      all_done_flag <= 1'b0;
    end
  end

  // interrupt follows the flags one cycle later, gated by the enables
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (done_half_reg && channel_control_reg[dmac_pkg::CTRL_HALF_DONE_IE])
                 || (all_done_flag && channel_control_reg[dmac_pkg::CTRL_ALL_DONE_IE]);
    end
  end

  // registered copy of the request for peers; lags own arbitration by one
  always_ff @(posedge clock) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= want;
    end
  end

  assign half_done_flag = done_half_reg;
  assign irq = irq_reg;
  assign pending = pending_reg;
  assign periph_ack = ack_reg;
  assign bus_req = req_reg;
  assign bus_write = write_reg;
  assign bus_addr = addr_reg;
  assign bus_size = size_reg;
  assign bus_wdata = wdata_reg;

endmodule

// ==== bench/dmac_channel_sva.sv ====
// Purpose: concurrent checks on the dma channel ports
// Assumes: single clock, synchronous active-high reset
// Notes: sees only top ports; attached by bind below
`timescale 1ns/1ns
module dmac_channel_sva (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic periph_req, // peripheral request
  input wire logic periph_ack, // acknowledge
  input wire logic bus_req, // bus access active
  input wire logic bus_write, // write beat
  input wire logic bus_ready, // beat done
  input wire logic periph_base_we, // base strobe
  input wire logic mem_base_we, // base strobe
  input wire logic [dmac_pkg::CTRL_W-1:0] channel_control_reg, // control
  input wire logic [dmac_pkg::ADDR_W-1:0] peripheral_base_addr_reg, // base
  input wire logic [dmac_pkg::ADDR_W-1:0] memory_base_addr_reg, // base
  input wire logic [dmac_pkg::COUNT_W-1:0] remaining_items_reg, // count
  input wire logic half_done_flag, // half flag
  input wire logic all_done_flag, // done flag
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence read_done;
    bus_req && !bus_write && bus_ready;
  endsequence
  sequence write_done;
    bus_req && bus_write && bus_ready;
  endsequence
  AST_ACK_CAUSE: assert property ($rose(periph_ack) |-> $past(periph_req))
    else $error("ack rose without request");
  AST_ACK_HOLD: assert property (periph_ack && periph_req |=> periph_ack)
    else $error("ack dropped while request held");
  AST_ACK_DROP: assert property (periph_ack && !periph_req |-> ##[1:6] !periph_ack)
    else $error("ack not released");
  AST_NO_SERVE_ZERO: assert property (remaining_items_reg == 16'h0000 && !bus_req |=> !bus_req)
    else $error("access with zero count");
  AST_IDLE_OFF: assert property (!channel_control_reg[0] && !bus_req |=> !bus_req)
    else $error("access while disabled");
  AST_COUNT_DEC: assert property (write_done |=> (remaining_items_reg ==
    $past(remaining_items_reg) - 16'h0001) || ($past(remaining_items_reg) == 16'h0001))
    else $error("count not lowered by one");
  AST_ALL_DONE: assert property (write_done ##0 (remaining_items_reg == 16'h0001) |=>
    all_done_flag)
    else $error("done flag missing");
  AST_IRQ: assert property (1'b1 |=> irq ==
    $past((half_done_flag && channel_control_reg[dmac_pkg::CTRL_HALF_DONE_IE])
    || (all_done_flag && channel_control_reg[dmac_pkg::CTRL_ALL_DONE_IE])))
    else $error("irq mismatch");
  AST_READ_WRITE: assert property (read_done |=> bus_req && bus_write)
    else $error("write beat missing after read");
  AST_BASE_KEEP: assert property (!periph_base_we && !mem_base_we |=>
    $stable(peripheral_base_addr_reg) && $stable(memory_base_addr_reg))
    else $error("base register changed");
endmodule
bind dmac_channel dmac_channel_sva dmac_channel_sva_inst (.clock, .rst, .periph_req,
  .periph_ack, .bus_req, .bus_write, .bus_ready, .periph_base_we, .mem_base_we,
  .channel_control_reg, .peripheral_base_addr_reg, .memory_base_addr_reg,
  .remaining_items_reg, .half_done_flag, .all_done_flag, .irq);

// ==== bench/dmac_far_model.sv ====
// Purpose: peripheral request line and system bus slave facing the channel
// Assumes: ready is a one-cycle pulse after wait_cycles idle cycles
// Notes: read data toggles outside a beat so stale values never look valid
`timescale 1ns/1ns
module dmac_far_model (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic start, // load request budget
  input wire logic [3:0] num_req, // requests to raise
  input wire logic [1:0] wait_cycles, // bus wait states
  input wire logic periph_ack, // acknowledge from channel
  input wire logic bus_req, // access active
  input wire logic [31:0] bus_addr, // access address
  output logic periph_req, // request to channel
  output logic bus_ready, // beat done
  output logic [31:0] bus_rdata // read data
);
  logic [3:0] left_reg;
  logic [1:0] wait_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      periph_req <= 1'b0;
      left_reg <= 4'h0;
    end else if (start) begin
      left_reg <= num_req;
    end else if (periph_req && periph_ack) begin
      periph_req <= 1'b0;
    end else if (!periph_req && !periph_ack && left_reg != 4'h0) begin
      periph_req <= 1'b1;
      left_reg <= left_reg - 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst || !bus_req || bus_ready) begin
      bus_ready <= 1'b0;
      wait_reg <= 2'h0;
    end else if (wait_reg == wait_cycles) begin
      bus_ready <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) bus_rdata <= 32'h0000_0000;
    else if (bus_req && !bus_ready) bus_rdata <= {bus_addr[15:0] ^ 16'h5ac3, bus_addr[15:0]};
    else bus_rdata <= ~bus_rdata;
  end
endmodule

// ==== bench/dmac_channel_tb.sv ====
// Purpose: self-checking bench of one dma channel
// Assumes: channel number 2, far side from dmac_far_model
// Notes: every bus beat is queued by a monitor and judged in order
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (b)); end end
module dmac_channel_tb;
  logic clock = 1'b0, rst = 1'b1, start = 1'b0;
  logic control_we = 1'b0, periph_base_we = 1'b0, mem_base_we = 1'b0, count_we = 1'b0;
  logic [13:0] control_wdata = 14'h0000;
  logic [31:0] periph_base_wdata = 32'h0, mem_base_wdata = 32'h0, bus_rdata, bus_addr, bus_wdata;
  logic [15:0] count_wdata = 16'h0, peer_levels = 16'h0, remaining_items_reg;
  logic half_done_clear = 1'b0, all_done_clear = 1'b0, periph_req, bus_ready;
  logic [7:0] peer_pending = 8'h00;
  logic [3:0] num_req = 4'h0;
  logic [1:0] wait_cycles = 2'h0, bus_size;
  logic [13:0] channel_control_reg;
  logic [31:0] peripheral_base_addr_reg, memory_base_addr_reg;
  logic half_done_flag, all_done_flag, irq, periph_ack, bus_req, bus_write, pending;
  logic [66:0] beats[$];
  int num_errors = 0, total_checks = 0;
  dmac_channel #(.NCH(8), .CH_INDEX(2)) dmac_channel_inst (.clock, .rst, .control_we,
    .control_wdata, .periph_base_we, .periph_base_wdata, .mem_base_we, .mem_base_wdata,
    .count_we, .count_wdata, .half_done_clear, .all_done_clear, .periph_req, .peer_pending,
    .peer_levels, .bus_ready, .bus_rdata, .channel_control_reg, .peripheral_base_addr_reg,
    .memory_base_addr_reg, .remaining_items_reg, .half_done_flag, .all_done_flag, .irq,
    .pending, .periph_ack, .bus_req, .bus_write, .bus_addr, .bus_size, .bus_wdata);
  dmac_far_model dmac_far_model_inst (.clock, .rst, .start, .num_req, .wait_cycles,
    .periph_ack, .bus_req, .bus_addr, .periph_req, .bus_ready, .bus_rdata);
  always #5 clock = ~clock;
  always @(posedge clock) if (!rst && bus_req === 1'b1 && bus_ready === 1'b1)
    beats.push_back({bus_write, bus_size, bus_addr, bus_write ? bus_wdata : bus_rdata});
  function automatic logic [31:0] keep(input logic [31:0] d, input logic [1:0] w);
    keep = (w == 2'h2) ? d : (w == 2'h1) ? (d & 32'h0000_ffff) : (d & 32'h0000_00ff);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic strobe(input int which);
    @(posedge clock);
    count_we <= (which == 0);
    control_we <= (which == 1);
    half_done_clear <= (which == 2);
    all_done_clear <= (which == 2);
    @(posedge clock);
    {count_we, control_we, half_done_clear, all_done_clear} <= 4'h0;
    repeat (3) @(posedge clock);
  endtask
  // software order: bases, count, options, then enable
  task automatic cfg(input logic [31:0] pb, mb, input logic [15:0] n, input logic [13:0] c);
    @(posedge clock);
    periph_base_we <= 1'b1;
    periph_base_wdata <= pb;
    @(posedge clock);
    periph_base_we <= 1'b0;
    mem_base_we <= 1'b1;
    mem_base_wdata <= mb;
    @(posedge clock);
    mem_base_we <= 1'b0;
    count_wdata <= n;
    control_wdata <= c & 14'h3ffe;
    strobe(0);
    strobe(1);
    control_wdata <= c;
    strobe(1);
  endtask
  task automatic run_req(input logic [3:0] n);
    @(posedge clock);
    start <= 1'b1;
    num_req <= n;
    @(posedge clock);
    start <= 1'b0;
  endtask
  task automatic chk_item(input logic [31:0] sa, input logic [1:0] sw, input logic [31:0] da,
                          input logic [1:0] dw);
    logic [66:0] r, w;
    for (int k = 0; k < 300 && beats.size() < 2; k++) @(posedge clock);
    if (beats.size() < 2) begin
      num_errors++;
      return;
    end
    r = beats.pop_front();
    w = beats.pop_front();
    `CHK(r[66:32], {1'b0, sw, sa})
    `CHK(w[66:32], {1'b1, dw, da})
    `CHK(w[31:0], keep(keep(r[31:0], sw), dw))
  endtask
  task automatic t_periph();
    cfg(32'h4000_0010, 32'h2000_0100, 16'h0004, 14'h1267);
    `CHK(channel_control_reg, 14'h1267)
    run_req(4'h5);
    for (int i = 0; i < 4; i++) begin
      chk_item(32'h4000_0010 + i, 2'h0, 32'h2000_0100 + 2 * i, 2'h1);
      if (i == 1) begin
        repeat (3) @(posedge clock);
        `CHK({half_done_flag, all_done_flag, irq}, 3'b101)
      end
    end
    repeat (20) @(posedge clock);
    `CHK(beats.size(), 0)
    `CHK({periph_req, periph_ack, remaining_items_reg, all_done_flag, irq}, 20'h80003)
    count_wdata <= 16'h0007;
    strobe(0);
    `CHK(remaining_items_reg, 16'h0000)
    control_wdata <= 14'h1266;
    strobe(1);
    `CHK({channel_control_reg, peripheral_base_addr_reg, memory_base_addr_reg},
         {14'h1266, 32'h4000_0010, 32'h2000_0100})
    strobe(2);
    `CHK({half_done_flag, all_done_flag, irq}, 3'b000)
    $display("test periph_to_mem done");
  endtask
  task automatic t_wrap();
    cfg(32'h4000_0020, 32'h2000_0200, 16'h0002, 14'h0153);
    run_req(4'h3);
    for (int i = 0; i < 4; i++)
      chk_item(32'h4000_0020, 2'h2, 32'h2000_0200 + (i % 2), 2'h0);
    repeat (20) @(posedge clock);
    `CHK({remaining_items_reg, all_done_flag, periph_req}, 18'h00a)
    `CHK(beats.size(), 0)
    control_wdata <= 14'h0152;
    strobe(1);
    strobe(2);
    $display("test wraparound done");
  endtask
  task automatic t_bytes();
    cfg(32'h4000_0080, 32'h2000_0400, 16'h0002, 14'h0061);
    run_req(4'h2);
    for (int i = 0; i < 2; i++)
      chk_item(32'h4000_0080 + i, 2'h0, 32'h2000_0400 + i, 2'h0);
    control_wdata <= 14'h0060;
    strobe(1);
    strobe(2);
    $display("test byte_copy done");
  endtask
  task automatic t_copy();
    wait_cycles <= 2'h2;
    peer_pending <= 8'h02;
    peer_levels <= 16'h0004;
    cfg(32'h4000_0040, 32'h2000_0300, 16'h0003, 14'h2b69);
    repeat (20) @(posedge clock);
    `CHK({beats.size() == 0, bus_req}, 2'b10)
    `CHK(pending, 1'b1)
    peer_pending <= 8'h08;
    peer_levels <= 16'h0040;
    for (int i = 0; i < 3; i++)
      chk_item(32'h2000_0300 + 2 * i, 2'h1, 32'h4000_0040 + 4 * i, 2'h2);
    repeat (20) @(posedge clock);
    `CHK(beats.size(), 0)
    `CHK({remaining_items_reg, all_done_flag, periph_ack}, 18'h002)
    $display("test memory_copy done");
  endtask
  // whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHK({channel_control_reg, remaining_items_reg, bus_req, periph_ack, irq}, 33'h0)
    t_periph();
    t_wrap();
    t_bytes();
    t_copy();
    complete_run();
  end
endmodule
